/* File: design/snc_config_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module snc_config_regs
	import snc_pkg::*;
#(
	parameter logic [7:0]  SW_VERSION    = 8'h01,
	parameter logic [7:0]  SW_REVISION   = 8'h00,
	parameter logic [7:0]  NUM_LINKS     = 8'h08,
	parameter logic [7:0]  NUM_SW_PROCS  = 8'h01,
	parameter logic [7:0]  NUM_DEV_PROCS = 8'h01,
	parameter logic [31:0] PLL_RESET_VAL = 32'h0000_0000
) (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	// configuration requests
	input  wire snc_cfg_req_t          cfg_req,
	output logic                       cfg_ready,
	output snc_cfg_rsp_t               cfg_rsp,
	// boot pins and otp copies
	input  wire logic [7:0]            boot_control_pins,
	input  wire logic [31:0]           jtag_id_otp,
	input  wire logic [13:0]           user_code_otp,
	input  wire logic [17:0]           fix_id_code,
	// controls to the clocking and switch logic
	output logic                       one_byte_header,
	output snc_pll_t                   pll_settings,
	output logic                       pll_apply,
	output logic                       tile_reset_req,
	output logic                       pll_wait_lock,
	output logic [SNC_HALF_W-1:0]      switch_clk_div,
	output logic [SNC_HALF_W-1:0]      ref_clk_div,
	output logic [SNC_NODE_W-1:0]      node_id,
	// routing lookup
	input  wire logic                  route_req,
	input  wire logic [SNC_NODE_W-1:0] route_dest,
	output logic                       route_valid,
	output logic                       route_local,
	output logic [SNC_DIR_W-1:0]       route_dir
);

	logic [31:0]           sw_cfg_ff;
	logic [SNC_NODE_W-1:0] node_id_ff;
	logic [31:0]           pll_ff;
	logic [SNC_HALF_W-1:0] sw_clkdiv_ff;
	logic [SNC_HALF_W-1:0] ref_clk_ff;
	logic [31:0]           dir_lo_ff;
	logic [31:0]           dir_hi_ff;
	logic [7:0]            boot_ff;
	logic                  boot_taken_ff;
	snc_cfg_rsp_t          rsp_ff;
	logic                  pll_apply_ff;
	logic                  tile_rst_ff;
	logic                  pll_wait_ff;
	logic                  route_valid_ff;
	logic                  route_local_ff;
	logic [SNC_DIR_W-1:0]  route_dir_ff;

	logic         wr_req;
	logic         ctl_lock;
	logic         pll_lock;
	logic         wr_ok;
	logic         pll_wr;
	logic [31:0]  nxt_rdata;
	logic         nxt_err;
	logic [63:0]  dir_table;
	logic [SNC_NODE_W-1:0] mismatch;

	assign cfg_ready = 1'b1;
	assign wr_req    = cfg_req.valid && cfg_req.write;
	// the lock bit guards itself too: once set, only reset clears it
	assign ctl_lock  = sw_cfg_ff[SNC_CFG_CTL_LOCK_BIT];
	assign pll_lock  = sw_cfg_ff[SNC_CFG_PLL_LOCK_BIT];
	assign wr_ok     = wr_req && !ctl_lock;
	assign pll_wr    = wr_ok && !pll_lock &&
		(cfg_req.addr == SNC_ADDR_PLL);

	// boot pins caught at the first edge after reset release
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_ff       <= 8'h00;
			boot_taken_ff <= 1'b0;
		end else if (!boot_taken_ff) begin
			boot_ff       <= boot_control_pins;
			boot_taken_ff <= 1'b1;
		end
	end

	// writable control registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sw_cfg_ff    <= SNC_RST_SW_CFG;
			node_id_ff   <= SNC_RST_NODE_ID;
			sw_clkdiv_ff <= SNC_RST_SW_CLKDIV;
			ref_clk_ff   <= SNC_RST_REF_CLK;
			dir_lo_ff    <= SNC_RST_DIR;
			dir_hi_ff    <= SNC_RST_DIR;
		end else if (wr_ok) begin
			if (cfg_req.addr == SNC_ADDR_SW_CFG) begin
				sw_cfg_ff[SNC_CFG_CTL_LOCK_BIT] <=
					cfg_req.wdata[SNC_CFG_CTL_LOCK_BIT];
				sw_cfg_ff[SNC_CFG_PLL_LOCK_BIT] <=
					cfg_req.wdata[SNC_CFG_PLL_LOCK_BIT];
				sw_cfg_ff[SNC_CFG_HDR_BIT] <=
					cfg_req.wdata[SNC_CFG_HDR_BIT];
			end else if (cfg_req.addr == SNC_ADDR_NODE_ID) begin
				node_id_ff <= cfg_req.wdata[SNC_NODE_W-1:0];
			end else if (cfg_req.addr == SNC_ADDR_SW_CLKDIV) begin
				sw_clkdiv_ff <= cfg_req.wdata[SNC_HALF_W-1:0];
			end else if (cfg_req.addr == SNC_ADDR_REF_CLK) begin
				ref_clk_ff <= cfg_req.wdata[SNC_HALF_W-1:0];
			end else if (cfg_req.addr == SNC_ADDR_DIR_LO) begin
				dir_lo_ff <= cfg_req.wdata;
			end else if (cfg_req.addr == SNC_ADDR_DIR_HI) begin
				dir_hi_ff <= cfg_req.wdata;
			end
		end
	end

	// pll settings; reserved bits never stored
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pll_ff <= PLL_RESET_VAL & SNC_PLL_WR_MASK;
		end else if (pll_wr) begin
			pll_ff <= cfg_req.wdata & SNC_PLL_WR_MASK;
		end
	end

	// one-cycle side effects of an accepted pll write
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pll_apply_ff <= 1'b0;
			tile_rst_ff  <= 1'b0;
			pll_wait_ff  <= 1'b0;
		end else begin
			pll_apply_ff <= pll_wr;
			tile_rst_ff  <= pll_wr &&
				!cfg_req.wdata[SNC_PLL_NO_RESET_BIT];
			pll_wait_ff  <= pll_wr &&
				!cfg_req.wdata[SNC_PLL_NO_WAIT_BIT];
		end
	end

	// read mux
	always_comb begin
		nxt_rdata = SNC_ZERO;
		nxt_err   = 1'b0;
		if (cfg_req.addr == SNC_ADDR_DEV_ID) begin
			nxt_rdata = {8'h00, boot_ff, SW_REVISION, SW_VERSION};
		end else if (cfg_req.addr == SNC_ADDR_SW_DESC) begin
			nxt_rdata = {8'h00, NUM_LINKS, NUM_SW_PROCS,
				NUM_DEV_PROCS};
		end else if (cfg_req.addr == SNC_ADDR_SW_CFG) begin
			nxt_rdata = sw_cfg_ff;
		end else if (cfg_req.addr == SNC_ADDR_NODE_ID) begin
			nxt_rdata = {16'h0000, node_id_ff};
		end else if (cfg_req.addr == SNC_ADDR_PLL) begin
			nxt_rdata = pll_ff;
		end else if (cfg_req.addr == SNC_ADDR_SW_CLKDIV) begin
			nxt_rdata = {16'h0000, sw_clkdiv_ff};
		end else if (cfg_req.addr == SNC_ADDR_REF_CLK) begin
			nxt_rdata = {16'h0000, ref_clk_ff};
		end else if (cfg_req.addr == SNC_ADDR_JTAG_ID) begin
			nxt_rdata = jtag_id_otp;
		end else if (cfg_req.addr == SNC_ADDR_USERCODE) begin
			nxt_rdata = {user_code_otp, fix_id_code};
		end else if (cfg_req.addr == SNC_ADDR_DIR_LO) begin
			nxt_rdata = dir_lo_ff;
		end else if (cfg_req.addr == SNC_ADDR_DIR_HI) begin
			nxt_rdata = dir_hi_ff;
		end else begin
			nxt_err = 1'b1;
		end
	end

	// answer one cycle after the request; writes return no data
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff.ack   <= cfg_req.valid;
			rsp_ff.err   <= cfg_req.valid && nxt_err;
			rsp_ff.rdata <= (cfg_req.valid && !cfg_req.write) ?
				nxt_rdata : SNC_ZERO;
		end
	end

	// routing: highest differing bit selects the nibble
	assign dir_table = {dir_hi_ff, dir_lo_ff};
	assign mismatch  = route_dest ^ node_id_ff;

	function automatic logic [SNC_DIR_W-1:0] pick_dir(
		input logic [SNC_NODE_W-1:0] mm,
		input logic [63:0]           tbl
	);
		logic [SNC_DIR_W-1:0] d;
		d = '0;
		for (int k = 0; k < SNC_DIMS; k++) begin
			if (mm[k]) begin
				d = tbl[k*SNC_DIR_W +: SNC_DIR_W];
			end
		end
		return d;
	endfunction

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			route_valid_ff <= 1'b0;
			route_local_ff <= 1'b0;
			route_dir_ff   <= '0;
		end else begin
			route_valid_ff <= route_req;
			if (route_req) begin
				route_local_ff <= (mismatch == '0);
				route_dir_ff   <= pick_dir(mismatch, dir_table);
			end
		end
	end

	assign cfg_rsp         = rsp_ff;
	assign one_byte_header = sw_cfg_ff[SNC_CFG_HDR_BIT];
	// fields picked by position; a plain cast would misalign them
	assign pll_settings    = '{
		no_reset:  pll_ff[SNC_PLL_NO_RESET_BIT],
		no_wait:   pll_ff[SNC_PLL_NO_WAIT_BIT],
		bypass:    pll_ff[SNC_PLL_BYPASS_BIT],
		boot_jtag: pll_ff[SNC_PLL_JTAG_BIT],
		p_div:     pll_ff[SNC_PLL_P_LSB +: SNC_PLL_P_W],
		m_mul:     pll_ff[SNC_PLL_M_LSB +: SNC_PLL_M_W],
		n_div:     pll_ff[SNC_PLL_N_LSB +: SNC_PLL_N_W]
	};
	assign pll_apply       = pll_apply_ff;
	assign tile_reset_req  = tile_rst_ff;
	assign pll_wait_lock   = pll_wait_ff;
	assign switch_clk_div  = sw_clkdiv_ff;
	assign ref_clk_div     = ref_clk_ff;
	assign node_id         = node_id_ff;
	assign route_valid     = route_valid_ff;
	assign route_local     = route_local_ff;
	assign route_dir       = route_dir_ff;

	// checks
	a_ctl_lock_holds: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		ctl_lock |=> $stable(node_id_ff) && $stable(dir_lo_ff) &&
			$stable(ref_clk_ff) && $stable(sw_cfg_ff))
		else $error("control register changed while locked");

	a_pll_lock_holds: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(pll_lock || ctl_lock) |=> $stable(pll_ff) && !pll_apply_ff)
		else $error("pll register changed while locked");

	a_pll_reset_pulse: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(wr_req && !ctl_lock && !pll_lock &&
			cfg_req.addr == SNC_ADDR_PLL &&
			!cfg_req.wdata[SNC_PLL_NO_RESET_BIT])
		|=> tile_reset_req ##1 (tile_reset_req ==
			$past(pll_wr && !cfg_req.wdata[SNC_PLL_NO_RESET_BIT])))
		else $error("pll write did not pulse tile reset");

	a_pll_ctl_bits: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		pll_wr |=> pll_settings.bypass ==
			$past(cfg_req.wdata[SNC_PLL_BYPASS_BIT]) &&
			pll_settings.boot_jtag == $past(cfg_req.wdata[SNC_PLL_JTAG_BIT]))
		else $error("pll bypass or boot bit not applied");

	a_pll_dividers: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		pll_wr |=>
			pll_settings.p_div ==
				$past(cfg_req.wdata[SNC_PLL_P_LSB +: SNC_PLL_P_W]) &&
			pll_settings.m_mul ==
				$past(cfg_req.wdata[SNC_PLL_M_LSB +: SNC_PLL_M_W]) &&
			pll_settings.n_div ==
				$past(cfg_req.wdata[SNC_PLL_N_LSB +: SNC_PLL_N_W]))
		else $error("pll divider fields not applied");

	a_lock_silent: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(wr_req && ctl_lock && !nxt_err)
		|=> cfg_rsp.ack && !cfg_rsp.err && !pll_apply)
		else $error("locked write not dropped silently");

	a_pll_no_reset: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		tile_reset_req |-> pll_apply && !pll_settings.no_reset)
		else $error("tile reset without a resetting pll write");

	a_pll_no_wait: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		pll_apply |-> (pll_wait_lock == !pll_settings.no_wait))
		else $error("lock wait disagrees with stored bit");

	a_node_id_write: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(wr_req && !ctl_lock && cfg_req.addr == SNC_ADDR_NODE_ID)
		|=> node_id == $past(cfg_req.wdata[SNC_NODE_W-1:0]))
		else $error("node id write not stored");

	a_dev_id_read: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(cfg_req.valid && !cfg_req.write &&
			cfg_req.addr == SNC_ADDR_DEV_ID)
		|=> cfg_rsp.ack && cfg_rsp.rdata[15:0] ==
			{SW_REVISION, SW_VERSION} && cfg_rsp.rdata[31:24] == 8'h00)
		else $error("identity read wrong");

	a_desc_read: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(cfg_req.valid && !cfg_req.write &&
			cfg_req.addr == SNC_ADDR_SW_DESC)
		|=> cfg_rsp.ack && cfg_rsp.rdata ==
			{8'h00, NUM_LINKS, NUM_SW_PROCS, NUM_DEV_PROCS})
		else $error("description read wrong");

	a_usercode_read: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(cfg_req.valid && !cfg_req.write &&
			cfg_req.addr == SNC_ADDR_USERCODE)
		|=> cfg_rsp.rdata == {$past(user_code_otp), $past(fix_id_code)})
		else $error("user code read wrong");

	a_route_local: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(route_req && route_dest == node_id_ff && !wr_req)
		|=> route_valid && route_local)
		else $error("own node id not flagged local");

	a_route_top_dim: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(route_req && mismatch[SNC_DIMS-1])
		|=> route_dir == $past(dir_hi_ff[31:28]))
		else $error("top dimension direction wrong");

	a_hdr_follows: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(wr_req && !ctl_lock && cfg_req.addr == SNC_ADDR_SW_CFG)
		|=> one_byte_header == $past(cfg_req.wdata[SNC_CFG_HDR_BIT]))
		else $error("header mode not updated");

endmodule
`default_nettype wire

/* File: design/snc_pkg.sv */
package snc_pkg;

	// register numbers as seen by configuration requests
	localparam logic [7:0] SNC_ADDR_DEV_ID    = 8'h00;
	localparam logic [7:0] SNC_ADDR_SW_DESC   = 8'h01;
	localparam logic [7:0] SNC_ADDR_SW_CFG    = 8'h04;
	localparam logic [7:0] SNC_ADDR_NODE_ID   = 8'h05;
	localparam logic [7:0] SNC_ADDR_PLL       = 8'h06;
	localparam logic [7:0] SNC_ADDR_SW_CLKDIV = 8'h07;
	localparam logic [7:0] SNC_ADDR_REF_CLK   = 8'h08;
	localparam logic [7:0] SNC_ADDR_JTAG_ID   = 8'h09;
	localparam logic [7:0] SNC_ADDR_USERCODE  = 8'h0A;
	localparam logic [7:0] SNC_ADDR_DIR_LO    = 8'h0C;
	localparam logic [7:0] SNC_ADDR_DIR_HI    = 8'h0D;

	// switch configuration fields
	localparam int SNC_CFG_CTL_LOCK_BIT = 31;
	localparam int SNC_CFG_PLL_LOCK_BIT = 8;
	localparam int SNC_CFG_HDR_BIT      = 0;

	// pll settings fields
	localparam int SNC_PLL_NO_RESET_BIT = 31;
	localparam int SNC_PLL_NO_WAIT_BIT  = 30;
	localparam int SNC_PLL_BYPASS_BIT   = 29;
	localparam int SNC_PLL_JTAG_BIT     = 28;
	// reserved 27:26, 22:21 and 7 are never stored
	localparam logic [31:0] SNC_PLL_WR_MASK = 32'hF39F_FF7F;
	localparam int SNC_PLL_P_LSB = 23;
	localparam int SNC_PLL_P_W   = 3;
	localparam int SNC_PLL_M_LSB = 8;
	localparam int SNC_PLL_M_W   = 13;
	localparam int SNC_PLL_N_LSB = 0;
	localparam int SNC_PLL_N_W   = 7;

	// field widths
	localparam int SNC_NODE_W = 16;
	localparam int SNC_DIR_W  = 4;
	localparam int SNC_DIMS   = 16;
	localparam int SNC_HALF_W = 16;

	// reset values
	localparam logic [31:0] SNC_RST_SW_CFG    = 32'h0000_0000;
	localparam logic [15:0] SNC_RST_NODE_ID   = 16'h0000;
	localparam logic [15:0] SNC_RST_SW_CLKDIV = 16'h0000;
	localparam logic [15:0] SNC_RST_REF_CLK   = 16'h0003;
	localparam logic [31:0] SNC_RST_DIR       = 32'h0000_0000;
	localparam logic [31:0] SNC_ZERO          = 32'h0000_0000;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} snc_cfg_req_t;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [31:0] rdata;
	} snc_cfg_rsp_t;

	typedef struct packed {
		logic       no_reset;
		logic       no_wait;
		logic       bypass;
		logic       boot_jtag;
		logic [2:0] p_div;
		logic [12:0] m_mul;
		logic [6:0] n_div;
	} snc_pll_t;

endpackage

/* File: dv/snc_requester.sv */
`timescale 1ns/1ps
`default_nettype none
module snc_requester
	import snc_pkg::*;
(
	// clock
	input  wire logic         core_clk,
	// request side
	output var snc_cfg_req_t  cfg_req,
	input  wire snc_cfg_rsp_t cfg_rsp,
	input  wire logic         cfg_ready
);
	// idle cycles before each request, to act as a slow requester
	int gap = 0;

	initial cfg_req = '0;

	// released fields show the inverse, so stale values cannot pass
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output snc_cfg_rsp_t r, output logic ok);
		int i;
		repeat (gap) @(negedge core_clk);
		@(negedge core_clk);
		cfg_req = '{1'b1, wr, a, d};
		ok = 1'b0;
		r = '0;
		for (i = 0; i < 4 && !ok; i++) begin
			@(negedge core_clk);
			if (i == 0)
				cfg_req = '{1'b0, ~wr, ~a, ~d};
			if (cfg_rsp.ack === 1'b1 && cfg_ready === 1'b1) begin
				ok = 1'b1;
				r = cfg_rsp;
			end
		end
	endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import snc_pkg::*;
	// arbitrary identity values
	localparam logic [7:0]  VER = 8'h5A;
	localparam logic [7:0]  REV = 8'h3C;
	localparam logic [31:0] PMASK = 32'hF39F_FF7F;
	logic         core_clk, rst_n, cfg_ready, one_byte_header;
	snc_cfg_req_t cfg_req;
	snc_cfg_rsp_t cfg_rsp;
	snc_pll_t     pll_settings;
	logic [7:0]   boot_control_pins;
	logic [31:0]  jtag_id_otp, q;
	logic [13:0]  user_code_otp;
	logic [17:0]  fix_id_code;
	logic         pll_apply, tile_reset_req, pll_wait_lock, lerr;
	logic [15:0]  switch_clk_div, ref_clk_div, node_id, route_dest;
	logic         route_req, route_valid, route_local;
	logic [3:0]   route_dir;
	int           fails, checked;

	snc_config_regs #(.SW_VERSION(VER), .SW_REVISION(REV),
		.NUM_LINKS(8'h08), .NUM_SW_PROCS(8'h03), .NUM_DEV_PROCS(8'h06),
		.PLL_RESET_VAL(32'h0)) u_dut (
		.core_clk(core_clk), .rst_n(rst_n), .cfg_req(cfg_req),
		.cfg_ready(cfg_ready), .cfg_rsp(cfg_rsp),
		.boot_control_pins(boot_control_pins), .jtag_id_otp(jtag_id_otp),
		.user_code_otp(user_code_otp), .fix_id_code(fix_id_code),
		.one_byte_header(one_byte_header), .pll_settings(pll_settings),
		.pll_apply(pll_apply), .tile_reset_req(tile_reset_req),
		.pll_wait_lock(pll_wait_lock), .switch_clk_div(switch_clk_div),
		.ref_clk_div(ref_clk_div), .node_id(node_id),
		.route_req(route_req), .route_dest(route_dest),
		.route_valid(route_valid), .route_local(route_local),
		.route_dir(route_dir));

	snc_requester u_req (.core_clk(core_clk), .cfg_req(cfg_req),
		.cfg_rsp(cfg_rsp), .cfg_ready(cfg_ready));

	always #4 core_clk = ~core_clk;

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic acc(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		snc_cfg_rsp_t r;
		logic ok;
		u_req.xfer(wr, a, d, r, ok);
		chk("ack", 32'h1, {31'h0, ok});
		if (ok !== 1'b1)
			report_and_stop();
		q = r.rdata;
		lerr = r.err;
	endtask

	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask

	task automatic do_reset();
		rst_n = 1'b0;
		repeat (6) @(negedge core_clk);
		rst_n = 1'b1;
	endtask

	task automatic t_reset_vals();
		logic [7:0] ad[7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0C,
			8'h0D};
		logic [31:0] ex[7] = '{0, 0, 0, 0, 32'h3, 0, 0};
		for (int i = 0; i < 7; i++)
			rdc("reset value", ad[i], ex[i]);
		chk("ref port", 32'h3, {16'h0, ref_clk_div});
	endtask

	task automatic t_ident();
		boot_control_pins = 8'h3C;
		rdc("ident", 8'h00, {8'h00, 8'hA5, REV, VER});
		acc(1'b1, 8'h00, 32'hFFFF_FFFF);
		rdc("ident ro", 8'h00, {8'h00, 8'hA5, REV, VER});
		rdc("desc", 8'h01, 32'h0008_0306);
		rdc("usercode", 8'h0A, {14'h2A5C, 18'h12345});
		rdc("jtag id", 8'h09, 32'h1357_9BDF);
		rdc("unmapped", 8'h02, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, lerr});
	endtask

	task automatic t_rw();
		u_req.gap = 2;
		acc(1'b1, 8'h05, 32'hFFFF_ABCD);
		rdc("node", 8'h05, 32'h0000_ABCD);
		chk("node port", 32'hABCD, {16'h0, node_id});
		acc(1'b1, 8'h07, 32'hDEAD_1357);
		rdc("swdiv", 8'h07, 32'h1357);
		chk("swdiv port", 32'h1357, {16'h0, switch_clk_div});
		u_req.gap = 0;
		acc(1'b1, 8'h08, 32'h0001_FFFE);
		rdc("refdiv", 8'h08, 32'hFFFE);
		acc(1'b1, 8'h04, 32'h7FFF_FEFF);
		rdc("cfg", 8'h04, 32'h1);
		chk("header", 32'h1, {31'h0, one_byte_header});
		acc(1'b1, 8'h04, 32'h0);
		chk("header", 32'h0, {31'h0, one_byte_header});
	endtask

	task automatic t_pll();
		logic [31:0] w[5] = '{32'hBFFF_FFFF, 32'h0, 32'h3C80_0105,
			32'h8160_2A80, 32'h4100_2B00};
		logic [31:0] pv;
		// the only no-wait write nudges m by one, a gradual change
		foreach (w[i]) begin
			acc(1'b1, 8'h06, w[i]);
			chk("apply", 32'h1, {31'h0, pll_apply});
			chk("reset", {31'h0, ~w[i][31]}, {31'h0, tile_reset_req});
			chk("wait", {31'h0, ~w[i][30]}, {31'h0, pll_wait_lock});
			pv = {pll_settings.no_reset, pll_settings.no_wait,
				pll_settings.bypass, pll_settings.boot_jtag, 2'b00,
				pll_settings.p_div, 2'b00, pll_settings.m_mul, 1'b0,
				pll_settings.n_div};
			chk("pll port", w[i] & PMASK, pv);
			@(negedge core_clk);
			chk("pulses", 32'h0, {29'h0, pll_apply, tile_reset_req,
				pll_wait_lock});
			rdc("pll", 8'h06, w[i] & PMASK);
		end
	endtask

	task automatic t_route();
		acc(1'b1, 8'h05, 32'h1234);
		acc(1'b1, 8'h0C, 32'h7654_3210);
		acc(1'b1, 8'h0D, 32'hFEDC_BA98);
		rdc("dir hi", 8'h0D, 32'hFEDC_BA98);
		for (int k = 0; k <= 17; k++) begin
			@(negedge core_clk);
			if (k > 0) begin
				chk("rvalid", 32'h1, {31'h0, route_valid});
				chk("rlocal", {31'h0, k == 17}, {31'h0, route_local});
				chk("rdir", (k == 17) ? 0 : k - 1, {28'h0, route_dir});
			end
			route_req = (k < 17);
			route_dest = (k < 16) ? 16'h1234 ^ (16'h1 << k) ^
				(((16'h1 << k) - 16'h1) & 16'h5555) : 16'h1234;
		end
		@(negedge core_clk);
		chk("rvalid idle", 32'h0, {31'h0, route_valid});
	endtask

	task automatic t_lock();
		acc(1'b1, 8'h04, 32'h0000_0100);
		acc(1'b1, 8'h06, 32'h0);
		chk("locked pll", 32'h0, {30'h0, pll_apply, tile_reset_req});
		rdc("pll kept", 8'h06, 32'h4100_2B00);
		acc(1'b1, 8'h05, 32'h0055);
		rdc("node open", 8'h05, 32'h0055);
		acc(1'b1, 8'h04, 32'h8000_0101);
		acc(1'b1, 8'h05, 32'h00AA);
		chk("locked err", 32'h0, {31'h0, lerr});
		rdc("node locked", 8'h05, 32'h0055);
		acc(1'b1, 8'h04, 32'h0);
		rdc("cfg locked", 8'h04, 32'h8000_0101);
		do_reset();
		rdc("cfg after reset", 8'h04, 32'h0);
	endtask

	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		boot_control_pins = 8'hA5;
		jtag_id_otp = 32'h1357_9BDF;
		user_code_otp = 14'h2A5C;
		fix_id_code = 18'h12345;
		route_req = 1'b0;
		route_dest = 16'h0;
		fails = 0;
		checked = 0;
		do_reset();
		t_reset_vals();
		t_ident();
		t_rw();
		t_pll();
		t_route();
		t_lock();
		report_and_stop();
	end
endmodule
`default_nettype wire
